// ### mptb_pkg.sv
// package for the motor pwm time base: register map, fields, modes
// Operation
// (R1) 15-bit counter with prescaler and postscaler, readable
// (R2) counter bit 15 reads direction, down is one
// (R3) enable starts and stops; clear keeps counter value
// (R4) counter equals period: wrap or reverse next tick
// (R5) zero period stops counter and all events
// (R6) zero active period blocks transfer; disable first
// (R7) two-bit mode field selects four modes
// (R8) interrupts follow mode and postscale fields
// (R9) free-running counts to period, wraps, repeats
// (R10) free-running event per wrap, postscaled
// (R11) single-shot wraps once, hardware clears enable
// (R12) single-shot one event, postscaler ignored
// (R13) four duty generators, eight complementary outputs
// (R14) up/down reverses at period, event at zero
// (R15) double-update events at zero and period match
// (R16) prescaler 1:1, 1:4, 1:16, 1:64
// (R17) four-bit postscaler divides 1:1 to 1:16
// (R18) reset clears counter, direction, enable, mode, postscale
package mptb_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CNT    = 8'h04;
  localparam logic [7:0] ADDR_PER    = 8'h08;
  localparam logic [7:0] ADDR_STAT   = 8'h0c;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_DUTY0  = 8'h14;
  localparam int         NUM_DUTY    = 4;
  localparam int         CNT_W       = 15;
  localparam int         DIR_BIT     = 15;
  localparam logic [14:0] CNT_RESET  = 15'h0000;
  localparam logic [14:0] PER_RESET  = 15'h0000;
  localparam logic [14:0] DUTY_RESET = 15'h0000;
  localparam logic [5:0] PRESC_TERM1  = 6'h00;
  localparam logic [5:0] PRESC_TERM4  = 6'h03;
  localparam logic [5:0] PRESC_TERM16 = 6'h0f;
  localparam logic [5:0] PRESC_TERM64 = 6'h3f;

  typedef enum logic [1:0] {
    MPTB_FREE   = 2'h0,
    MPTB_SINGLE = 2'h1,
    MPTB_UPDN   = 2'h2,
    MPTB_DBL    = 2'h3
  } mptb_mode_t;

  // control word, bit 15 enable, 7:4 postscale, 3:2 prescale, 1:0 mode
  typedef struct packed {
    logic       time_base_enable;
    logic [6:0] rsvd;
    logic [3:0] interrupt_postscale_select;
    logic [1:0] input_prescale_select;
    mptb_mode_t time_base_mode_select;
  } mptb_ctrl_t;

  localparam mptb_ctrl_t CTRL_RESET = 16'h0000;
endpackage

// ### mptb_top.sv
// motor pwm time base with apb registers, interrupt and duty outputs
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module mptb_top
  import mptb_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  output var  logic        IRQ,
  output var  logic [3:0]  PWM_HIGH,
  output var  logic [3:0]  PWM_LOW
);
  logic              rst_meta_reg;
  logic              rst_n;
  mptb_ctrl_t        ctrl_reg;
  logic [14:0]       cnt_reg;
  logic [14:0]       cnt_next;
  logic              dir_reg;
  logic              dir_next;
  logic [14:0]       per_buf_reg;
  logic [14:0]       per_act_reg;
  logic [5:0]        presc_reg;
  logic [3:0]        post_reg;
  logic              stat_reg;
  logic              stat_next;
  logic              mask_reg;
  logic [14:0]       duty_reg [NUM_DUTY];
  logic              acc;
  logic              wr;
  logic              wr_ctrl;
  logic              wr_cnt;
  logic              tick;
  logic              run;
  logic              match;
  logic              ev_raw;
  logic              ev_post;
  logic              ev;
  logic              hw_stop;
  logic [5:0]        presc_term;
  logic              mapped;
  logic [31:0]       rd_data;

  // reset released through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // apb decode; write lands at the access edge with pready high
  assign acc     = PSEL && PENABLE && PREADY;
  assign wr      = acc && PWRITE;
  assign wr_ctrl = wr && (PADDR == ADDR_CTRL);
  assign wr_cnt  = wr && (PADDR == ADDR_CNT);

  always_comb begin
    mapped  = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (PADDR)
      ADDR_CTRL: rd_data = {16'h0000, ctrl_reg};
      ADDR_CNT:  rd_data = {16'h0000, dir_reg, cnt_reg}; // R1 R2
      ADDR_PER:  rd_data = {17'h00000, per_buf_reg};
      ADDR_STAT: rd_data = {31'h00000000, stat_reg};
      ADDR_MASK: rd_data = {31'h00000000, mask_reg};
      8'h14:     rd_data = {17'h00000, duty_reg[0]};
      8'h18:     rd_data = {17'h00000, duty_reg[1]};
      8'h1c:     rd_data = {17'h00000, duty_reg[2]};
      8'h20:     rd_data = {17'h00000, duty_reg[3]};
      default:   mapped  = 1'b0;
    endcase
  end

  // zero wait states: ready is raised in the setup cycle's wake
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= rd_data;
      end
    end
  end

  // prescaler; cleared on counter or control writes
  always_comb begin
    unique case (ctrl_reg.input_prescale_select)
      2'h0: presc_term = PRESC_TERM1;
      2'h1: presc_term = PRESC_TERM4;
      2'h2: presc_term = PRESC_TERM16;
      2'h3: presc_term = PRESC_TERM64;
    endcase
  end

  assign tick = (presc_reg == presc_term); // R16

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= 6'h00;
    end else if (wr_ctrl || wr_cnt || !ctrl_reg.time_base_enable || tick) begin
      presc_reg <= 6'h00; // R16
    end else begin
      presc_reg <= presc_reg + 6'h01;
    end
  end

  // zero active period freezes the counter and its events
  assign run   = ctrl_reg.time_base_enable && tick && (per_act_reg != 15'h0000); // R3 R5
  assign match = (cnt_reg == per_act_reg); // R4

  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    ev_raw   = 1'b0;
    ev_post  = 1'b0;
    hw_stop  = 1'b0;
    if (run) begin
      unique case (ctrl_reg.time_base_mode_select) // R7
        MPTB_FREE, MPTB_SINGLE: begin
          dir_next = 1'b0;
          if (match) begin
            cnt_next = 15'h0000; // R4 R9
            if (ctrl_reg.time_base_mode_select == MPTB_SINGLE) begin
              hw_stop = 1'b1; // R11
              ev_raw  = 1'b1; // R12
            end else begin
              ev_post = 1'b1; // R10
            end
          end else begin
            cnt_next = cnt_reg + 15'h0001;
          end
        end
        MPTB_UPDN, MPTB_DBL: begin
          if (!dir_reg && match) begin
            dir_next = 1'b1; // R4 R14
            cnt_next = cnt_reg - 15'h0001;
            ev_raw   = (ctrl_reg.time_base_mode_select == MPTB_DBL); // R15
          end else if (dir_reg && cnt_reg == 15'h0001) begin
            cnt_next = 15'h0000;
            if (ctrl_reg.time_base_mode_select == MPTB_DBL) begin
              ev_raw = 1'b1; // R15
            end else begin
              ev_post = 1'b1; // R14
            end
          end else if (dir_reg && cnt_reg == 15'h0000) begin
            dir_next = 1'b0;
            cnt_next = 15'h0001;
          end else if (dir_reg) begin
            cnt_next = cnt_reg - 15'h0001;
          end else begin
            cnt_next = cnt_reg + 15'h0001;
          end
        end
      endcase
    end
  end

  // postscaler divides only the free-running and up/down events
  assign ev = ev_raw || (ev_post && post_reg == ctrl_reg.interrupt_postscale_select); // R8 R17

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      post_reg <= 4'h0;
    end else if (wr_ctrl || wr_cnt || ev) begin
      post_reg <= 4'h0;
    end else if (ev_post) begin
      post_reg <= post_reg + 4'h1; // R17
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= CNT_RESET; // R18
      dir_reg <= 1'b0; // R18
    end else if (wr_cnt) begin
      cnt_reg <= PWDATA[14:0];
      dir_reg <= dir_next;
    end else begin
      cnt_reg <= cnt_next; // R3
      dir_reg <= dir_next;
    end
  end

  // software write beats a same-cycle hardware stop
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET; // R18
    end else if (wr_ctrl) begin
      ctrl_reg      <= PWDATA[15:0];
      ctrl_reg.rsvd <= 7'h00;
    end else if (hw_stop) begin
      ctrl_reg.time_base_enable <= 1'b0; // R11
    end
  end

  // period buffer moves to the active copy at wrap, zero, or disable
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      per_buf_reg <= PER_RESET;
      per_act_reg <= PER_RESET;
    end else begin
      if (wr && PADDR == ADDR_PER) begin
        per_buf_reg <= PWDATA[14:0];
      end
      if (!ctrl_reg.time_base_enable) begin
        per_act_reg <= per_buf_reg; // R6
      end else if (per_act_reg != 15'h0000 && run && cnt_next == 15'h0000) begin
        per_act_reg <= per_buf_reg; // R6
      end
    end
  end

  // sticky event flag, write one to clear, set wins
  assign stat_next = ev || (stat_reg && !(wr && PADDR == ADDR_STAT && PWDATA[0]));

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= 1'b0;
      mask_reg <= 1'b0;
      IRQ      <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (wr && PADDR == ADDR_MASK) begin
        mask_reg <= PWDATA[0];
      end
      IRQ <= stat_next && ((wr && PADDR == ADDR_MASK) ? PWDATA[0] : mask_reg);
    end
  end

  // duty generators; low side is always the complement
  for (genvar g = 0; g < NUM_DUTY; g++) begin : g_duty
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        duty_reg[g] <= DUTY_RESET;
        PWM_HIGH[g] <= 1'b0;
        PWM_LOW[g]  <= 1'b1;
      end else begin
        if (wr && PADDR == ADDR_DUTY0 + 8'(4 * g)) begin
          duty_reg[g] <= PWDATA[14:0];
        end
        PWM_HIGH[g] <= ctrl_reg.time_base_enable && (cnt_reg < duty_reg[g]); // R13
        PWM_LOW[g]  <= !(ctrl_reg.time_base_enable && (cnt_reg < duty_reg[g])); // R13
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  logic free_wrap;
  logic updn_turn;
  assign free_wrap = run && ctrl_reg.time_base_mode_select == MPTB_FREE && match && !wr_cnt;
  assign updn_turn = run && ctrl_reg.time_base_mode_select == MPTB_UPDN && !dir_reg && match;

  chk_zero_period_hold: assert property ( // R5
    ctrl_reg.time_base_enable && per_act_reg == 15'h0000 && !wr_cnt
    |=> $stable(cnt_reg) && !$rose(stat_reg))
    else $error("counter moved with zero period");
  chk_free_wrap_zero: assert property ( // R9
    free_wrap |=> cnt_reg == 15'h0000 && !dir_reg)
    else $error("free-running did not wrap to zero");
  chk_single_stop: assert property ( // R11
    run && ctrl_reg.time_base_mode_select == MPTB_SINGLE && match && !wr_ctrl && !wr_cnt
    |=> !ctrl_reg.time_base_enable && stat_reg && cnt_reg == 15'h0000)
    else $error("single-shot did not halt");
  chk_disable_hold: assert property ( // R3
    !ctrl_reg.time_base_enable && !wr_cnt |=> $stable(cnt_reg))
    else $error("counter moved while disabled");
  chk_updn_reverse: assert property ( // R14
    updn_turn && !wr_cnt |=> dir_reg ##0 $past(stat_reg) == stat_reg)
    else $error("up/down did not reverse quietly at period");
  chk_dbl_match_event: assert property ( // R15
    run && ctrl_reg.time_base_mode_select == MPTB_DBL && !dir_reg && match |=> stat_reg)
    else $error("double-update missed period event");
  chk_low_complement: assert property ( // R13
    PWM_LOW == ~PWM_HIGH)
    else $error("low output not complement of high");
  chk_presc_spacing: assert property ( // R16
    tick && ctrl_reg.input_prescale_select == 2'h2 && !wr_ctrl && !wr_cnt
    && ctrl_reg.time_base_enable |=> !tick [*8])
    else $error("prescale 1:16 ticked too soon");
  chk_period_blocked: assert property ( // R6
    ctrl_reg.time_base_enable && per_act_reg == 15'h0000 && !wr_ctrl
    |=> per_act_reg == 15'h0000)
    else $error("period loaded while active period zero");
  chk_irq_follows: assert property (
    stat_reg && mask_reg |-> IRQ)
    else $error("interrupt missing for masked-in flag");
  chk_irq_clear: assert property (
    !stat_reg |-> !IRQ)
    else $error("interrupt high with flag clear");
  // direction and event checks for each mode, then period copy and ready checks
  chk_up_modes_dir: assert property ( // R2
    run && (ctrl_reg.time_base_mode_select == MPTB_FREE
    || ctrl_reg.time_base_mode_select == MPTB_SINGLE) |=> !dir_reg)
    else $error("direction flag set while counting up");
  chk_single_no_post: assert property ( // R12
    run && ctrl_reg.time_base_mode_select == MPTB_SINGLE && match
    && ctrl_reg.interrupt_postscale_select != 4'h0 |=> stat_reg)
    else $error("single-shot event held back by postscaler");
  chk_free_post_hold: assert property ( // R17
    run && ctrl_reg.time_base_mode_select == MPTB_FREE && match && !stat_reg
    && post_reg != ctrl_reg.interrupt_postscale_select |=> !stat_reg)
    else $error("postscaler let an early event through");
  chk_updn_zero_event: assert property ( // R14
    run && ctrl_reg.time_base_mode_select == MPTB_UPDN && dir_reg && cnt_reg == 15'h0001
    && post_reg == ctrl_reg.interrupt_postscale_select && !wr_cnt
    |=> stat_reg && cnt_reg == 15'h0000)
    else $error("up/down missed zero event");
  chk_turn_upward: assert property ( // R14
    run && dir_reg && cnt_reg == 15'h0000 && !wr_cnt
    && (ctrl_reg.time_base_mode_select == MPTB_UPDN
    || ctrl_reg.time_base_mode_select == MPTB_DBL)
    |=> !dir_reg && cnt_reg == 15'h0001)
    else $error("counter did not turn upward at zero");
  chk_dbl_zero_event: assert property ( // R15
    run && ctrl_reg.time_base_mode_select == MPTB_DBL && dir_reg && cnt_reg == 15'h0001
    |=> stat_reg)
    else $error("double-update missed zero event");
  chk_period_follow: assert property ( // R6
    !ctrl_reg.time_base_enable |=> per_act_reg == $past(per_buf_reg))
    else $error("disabled period copy not loaded");
  chk_ready_single: assert property (
    PREADY |=> !PREADY)
    else $error("ready stood more than one cycle");

  cov_free_wrap: cover property (free_wrap);
  cov_updn_turn: cover property (updn_turn);
  cov_single_stop: cover property (hw_stop);
  cov_irq: cover property ($rose(IRQ));
  cov_dbl_zero: cover property (
    run && ctrl_reg.time_base_mode_select == MPTB_DBL && dir_reg && cnt_reg == 15'h0001);

endmodule // mptb_top
`default_nettype wire

// ### mptb_top_test.sv
// self-checking bench for the motor pwm time base
`timescale 1ns/10ps
`default_nettype none
module mptb_top_test import mptb_pkg::*; ;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        IRQ;
  logic [3:0]  PWM_HIGH;
  logic [3:0]  PWM_LOW;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          t;
  int          v;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  regs [5] = '{ADDR_CTRL, ADDR_CNT, ADDR_PER, ADDR_STAT, ADDR_MASK};

  mptb_top DUT (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ(IRQ), .PWM_HIGH(PWM_HIGH), .PWM_LOW(PWM_LOW));

  always #20 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until pready is sampled high, released only after that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  function automatic logic [31:0] ctl(logic en, logic [3:0] ps, logic [1:0] pre, mptb_mode_t m);
    mptb_ctrl_t c;
    c = CTRL_RESET;
    c.time_base_enable = en;
    c.interrupt_postscale_select = ps;
    c.input_prescale_select = pre;
    c.time_base_mode_select = m;
    return {16'h0000, c};
  endfunction

  // a zero active period only reloads while disabled, so stop first
  task automatic setup(mptb_mode_t m, logic [14:0] per, logic [3:0] ps, logic [1:0] pre);
    apb(1'b1, ADDR_CTRL, ctl(1'b0, ps, pre, m));
    apb(1'b1, ADDR_CNT, 32'h0);
    apb(1'b1, ADDR_PER, {17'h0, per});
    apb(1'b1, ADDR_STAT, 32'h1);
    apb(1'b1, ADDR_CTRL, ctl(1'b1, ps, pre, m));
  endtask

  task automatic wirq(input int lim, output int tm);
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (IRQ !== 1'b1 && n < lim);
    tm = (IRQ === 1'b1) ? cyc : -1;
  endtask

  // cycles between two interrupts, status cleared after each
  task automatic meas(input string nm, input int exp);
    int t1;
    int t2;
    wirq(300, t1);
    apb(1'b1, ADDR_STAT, 32'h1);
    wirq(300, t2);
    apb(1'b1, ADDR_STAT, 32'h1);
    chk(nm, exp, t2 - t1);
  endtask

  initial begin
    repeat (30000) @(posedge CLK);
    miscompares++;
    test_done;
  end

  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("low after reset", 32'hf, {28'h0, PWM_LOW});
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset word", 32'h0, rd);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    setup(MPTB_FREE, 15'h3, 4'h0, 2'h0);
    repeat (20) @(posedge CLK);
    chk("masked irq", 32'h0, {31'h0, IRQ});
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("masked status", 32'h1, rd);
    apb(1'b1, ADDR_MASK, 32'h1);
    for (int p = 0; p < 4; p++) begin
      setup(MPTB_FREE, 15'h3, 4'h0, p[1:0]);
      meas("prescaled wrap", 4 << (2 * p));
    end
    setup(MPTB_FREE, 15'h9, 4'h1, 2'h0);
    meas("postscale two", 20);
    setup(MPTB_FREE, 15'h3, 4'hf, 2'h0);
    meas("postscale sixteen", 64);
    setup(MPTB_SINGLE, 15'h5, 4'h3, 2'h0);
    wirq(50, t);
    chk("single event", 32'h1, {31'h0, IRQ});
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("single stops", ctl(1'b0, 4'h3, 2'h0, MPTB_SINGLE), rd);
    apb(1'b0, ADDR_CNT, 32'h0);
    chk("single count", 32'h0, rd);
    apb(1'b1, ADDR_STAT, 32'h1);
    repeat (30) @(posedge CLK);
    chk("single once", 32'h0, {31'h0, IRQ});
    setup(MPTB_FREE, 15'h64, 4'h0, 2'h0);
    repeat (20) @(posedge CLK);
    apb(1'b1, ADDR_CTRL, ctl(1'b0, 4'h0, 2'h0, MPTB_FREE));
    apb(1'b0, ADDR_CNT, 32'h0);
    v = rd;
    chk("up direction", 32'h0, {31'h0, rd[15]});
    repeat (5) @(posedge CLK);
    apb(1'b0, ADDR_CNT, 32'h0);
    chk("held count", v, rd);
    chk("count moved", 32'h1, {31'h0, v != 0});
    // zero period freezes, and the later period write must not load
    setup(MPTB_FREE, 15'h0, 4'h0, 2'h0);
    apb(1'b1, ADDR_CNT, 32'h5);
    apb(1'b1, ADDR_PER, 32'h3);
    repeat (40) @(posedge CLK);
    chk("zero period irq", 32'h0, {31'h0, IRQ});
    apb(1'b0, ADDR_CNT, 32'h0);
    chk("frozen count", 32'h5, rd);
    setup(MPTB_UPDN, 15'h4, 4'h0, 2'h0);
    meas("updown zero", 8);
    v = 0;
    repeat (12) begin
      apb(1'b0, ADDR_CNT, 32'h0);
      if (rd[15] === 1'b1) v = 1;
    end
    chk("down direction", 32'h1, v);
    setup(MPTB_DBL, 15'h6, 4'h5, 2'h0);
    // match at the top to the step into zero is one short of the period
    meas("double events", 5);
    setup(MPTB_FREE, 15'h9, 4'h0, 2'h0);
    apb(1'b1, ADDR_DUTY0, 32'h5);
    repeat (12) @(posedge CLK);
    v = 0;
    repeat (10) begin
      @(posedge CLK);
      #1;
      v += PWM_HIGH[0];
      chk("low pair", {28'h0, ~PWM_HIGH}, {28'h0, PWM_LOW});
    end
    chk("high cycles", 32'h5, v);
    test_done;
  end
endmodule // mptb_top_test
`default_nettype wire
